/* File: common/tcc_regs.svh */
// register offsets, field positions, reset values and codes for the timer block
// assumes an 8-bit register port with a 3-bit byte address
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

// register offsets
`define TCC_OFS_MSC      3'h0
`define TCC_OFS_CNT_HI   3'h1
`define TCC_OFS_CNT_LO   3'h2
`define TCC_OFS_MOD_HI   3'h3
`define TCC_OFS_MOD_LO   3'h4
`define TCC_OFS_CSC      3'h5
`define TCC_OFS_CVAL_HI  3'h6
`define TCC_OFS_CVAL_LO  3'h7

// main status/control fields
`define TCC_MSC_OVF      7
`define TCC_MSC_OVFIE    6
`define TCC_MSC_CPWM     5
`define TCC_MSC_CLK_HI   4
`define TCC_MSC_CLK_LO   3
`define TCC_MSC_PS_HI    2
`define TCC_MSC_PS_LO    0

// channel status/control fields
`define TCC_CSC_FLAG     7
`define TCC_CSC_IE       6
`define TCC_CSC_MSB      5
`define TCC_CSC_MSA      4
`define TCC_CSC_ELS_HI   3
`define TCC_CSC_ELS_LO   2

// clock source codes
`define TCC_CLK_NONE     2'h0
`define TCC_CLK_BUS      2'h1
`define TCC_CLK_FIXED    2'h2
`define TCC_CLK_EXT      2'h3

// edge/level codes
`define TCC_ELS_OFF      2'h0
`define TCC_ELS_01       2'h1
`define TCC_ELS_10       2'h2
`define TCC_ELS_11       2'h3

// reset and special values
`define TCC_ZERO16       16'h0000
`define TCC_FULL16       16'hffff
`define TCC_ZERO8        8'h00
`define TCC_ONE16        16'h0001

`endif

/* File: common/tcc_pkg.sv */
// types shared by the timer block
// assumes nothing beyond the register header
package tcc_pkg;

	// channel operating mode decoded from the channel mode bits and the main control CPWM bit
	typedef enum logic [1:0] {
		TCC_MODE_CAPTURE,
		TCC_MODE_COMPARE,
		TCC_MODE_EPWM,
		TCC_MODE_CENTER
	} tcc_mode_e;

endpackage

/* File: design/tcc_timer.sv */
// 16-bit timer with one channel, reached over a plain byte register port
// assumes one 40 MHz clock; the fixed, external and channel pins are asynchronous
//
// What this block does
// - clock select: stop, bus, fixed, external
// - prescaler divides by one to 128
// - counter byte read latches coherent 16-bit copy
// - reset or control write unlatches counter copy
// - counter byte write clears counter and latch
// - debug halt freezes counter and read latch
// - halt writes still unlatch counter copy
// - at modulo restart zero, set overflow
// - half-written modulo suppresses overflow flag
// - modulo resets zero, zero means free-run
// - stopped clock loads modulo on second byte
// - running loads modulo at period end
// - control write resets modulo write latch
// - halt modulo writes go straight through
// - channel flag on edge or match
// - channel interrupt is flag and enable
// - flag clears by read-then-write-zero
// - channel control bit layout
// - mode bits pick capture, compare, pwm
// - edge select picks capture edges
// - compare: none, toggle, or clear pin
// - compare select 11 sets pin
// - pwm polarity from edge select
// - overflow flag read-then-write-zero clear
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "tcc_regs.svh"

module tcc_timer (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// register port
	input  wire logic [2:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       write_i,
	input  wire logic       read_i,
	output logic      [7:0] rdata_o,
	// debug halt, same clock domain
	input  wire logic       debug_halt_i,
	// asynchronous clock pins
	input  wire logic       fixed_clk_i,
	input  wire logic       ext_clk_i,
	// channel pin
	input  wire logic       chan_pin_i,
	output logic            chan_pin_o,
	output logic            chan_pin_oe_o,
	// interrupt requests
	output logic            overflow_irq_o,
	output logic            chan_irq_o
);

	// prescale mask: divide-by-2^ps means a tick every 2^ps source edges
	function automatic logic [6:0] ps_mask(input logic [2:0] ps);
		ps_mask = 7'((8'h01 << ps) - 8'h01);
	endfunction

	// state
	logic [15:0] cnt_q, cnt_d, hold_q, mod_q, mod_buf_q, cval_q;
	logic [6:0]  pre_q;
	logic [7:0]  rdata_q;
	logic        ovf_q, ovfie_q, cpwm_q, ovf_arm_q;
	logic [1:0]  clks_q;
	logic [2:0]  ps_q;
	logic        cflag_q, cie_q, cmsb_q, cmsa_q, carm_q;
	logic [1:0]  els_q;
	logic        latched_q, first_hi_q;
	logic        mwr_hi_q, mwr_lo_q, mod_rdy_q, mod_wrap_q;
	logic        fx_s1_q, fx_s2_q, fx_p_q, ex_s1_q, ex_s2_q, ex_p_q;
	logic        pn_s1_q, pn_s2_q, pn_p_q, pin_q, tick_q;

	// register access decode
	wire wr_msc   = write_i && addr_i == `TCC_OFS_MSC;
	wire wr_cnt   = write_i && (addr_i == `TCC_OFS_CNT_HI || addr_i == `TCC_OFS_CNT_LO);
	wire wr_modh  = write_i && addr_i == `TCC_OFS_MOD_HI;
	wire wr_modl  = write_i && addr_i == `TCC_OFS_MOD_LO;
	wire wr_csc   = write_i && addr_i == `TCC_OFS_CSC;
	wire wr_cvh   = write_i && addr_i == `TCC_OFS_CVAL_HI;
	wire wr_cvl   = write_i && addr_i == `TCC_OFS_CVAL_LO;
	wire rd_msc   = read_i && addr_i == `TCC_OFS_MSC;
	wire rd_cnth  = read_i && addr_i == `TCC_OFS_CNT_HI;
	wire rd_cntl  = read_i && addr_i == `TCC_OFS_CNT_LO;
	wire rd_csc   = read_i && addr_i == `TCC_OFS_CSC;
	wire halt     = debug_halt_i;

	// channel mode decode
	tcc_pkg::tcc_mode_e mode;
	assign mode = cpwm_q ? tcc_pkg::TCC_MODE_CENTER :
	              cmsb_q ? tcc_pkg::TCC_MODE_EPWM :
	              cmsa_q ? tcc_pkg::TCC_MODE_COMPARE : tcc_pkg::TCC_MODE_CAPTURE;

	// source tick selection; the pins are only looked at after the second flop
	wire fx_rise  = fx_s2_q && !fx_p_q;
	wire ex_rise  = ex_s2_q && !ex_p_q;
	wire src_tick = (clks_q == `TCC_CLK_BUS)   ? 1'b1 :
	                (clks_q == `TCC_CLK_FIXED) ? fx_rise :
	                (clks_q == `TCC_CLK_EXT)   ? ex_rise : 1'b0;
	wire pre_wrap = pre_q >= ps_mask(ps_q);
	wire tick     = src_tick && pre_wrap && !halt;

	// counter next value and overflow
	wire         free_run = mod_q == `TCC_ZERO16;
	wire [15:0]  top      = free_run ? `TCC_FULL16 : mod_q;
	// a swap at the old top can leave the counter above the new one; wrap it anyway
	wire         at_top   = cnt_q == top || mod_wrap_q;
	wire [15:0]  cnt_inc  = at_top ? `TCC_ZERO16 : cnt_q + `TCC_ONE16;
	assign cnt_d = wr_cnt ? `TCC_ZERO16 : tick ? cnt_inc : cnt_q;
	wire         mod_pend = mwr_hi_q ^ mwr_lo_q;
	wire         ovf_set  = tick && at_top && !mod_pend;

	// modulo write completion (outside halt only)
	wire mod_done = !halt && ((wr_modh && mwr_lo_q) || (wr_modl && mwr_hi_q));
	wire [15:0] mod_new = wr_modh ? {wdata_i, mod_buf_q[7:0]} : {mod_buf_q[15:8], wdata_i};
	wire mod_apply = mod_rdy_q && tick && cnt_inc == top;

	// channel event detection
	wire pn_rise  = pn_s2_q && !pn_p_q;
	wire pn_fall  = !pn_s2_q && pn_p_q;
	wire cap_evt  = mode == tcc_pkg::TCC_MODE_CAPTURE &&
	                ((els_q[0] && pn_rise) || (els_q[1] && pn_fall));
	wire match    = tick_q && cnt_q == cval_q;
	wire duty_edge = cval_q == `TCC_ZERO16 || cval_q > top;                  // 0% or 100%
	wire cmp_evt  = match && (mode == tcc_pkg::TCC_MODE_COMPARE ||
	                (mode == tcc_pkg::TCC_MODE_EPWM && !duty_edge));
	wire ch_set   = cap_evt || cmp_evt;

	// flag clear sequences: the set always wins over the clear
	wire ovf_clr  = wr_msc && !wdata_i[`TCC_MSC_OVF] && ovf_arm_q;
	wire ch_clr   = wr_csc && !wdata_i[`TCC_CSC_FLAG] && carm_q;

	// read mux
	wire [15:0] cnt_view = (latched_q && !halt) ? hold_q : cnt_q;
	logic [7:0] rd_mux;
	always_comb begin
		case (addr_i)
			`TCC_OFS_MSC:     rd_mux = {ovf_q, ovfie_q, cpwm_q, clks_q, ps_q};
			`TCC_OFS_CNT_HI:  rd_mux = cnt_view[15:8];
			`TCC_OFS_CNT_LO:  rd_mux = cnt_view[7:0];
			`TCC_OFS_MOD_HI:  rd_mux = mod_q[15:8];
			`TCC_OFS_MOD_LO:  rd_mux = mod_q[7:0];
			`TCC_OFS_CSC:     rd_mux = {cflag_q, cie_q, cmsb_q, cmsa_q, els_q, 2'h0};
			`TCC_OFS_CVAL_HI: rd_mux = cval_q[15:8];
			`TCC_OFS_CVAL_LO: rd_mux = cval_q[7:0];
			default:          rd_mux = `TCC_ZERO8;
		endcase
	end

	// pin outputs and requests
	assign rdata_o        = rdata_q;
	assign chan_pin_o     = pin_q;
	assign chan_pin_oe_o  = els_q != `TCC_ELS_OFF && clks_q != `TCC_CLK_NONE &&
	                        (mode == tcc_pkg::TCC_MODE_COMPARE || mode == tcc_pkg::TCC_MODE_EPWM);
	assign overflow_irq_o = ovf_q && ovfie_q;
	assign chan_irq_o     = cflag_q && cie_q;

	// synchronisers and edge history; first flops feed only the second
	always_ff @(posedge clk_i) begin
		fx_s1_q <= fixed_clk_i;
		fx_s2_q <= fx_s1_q;
		fx_p_q  <= fx_s2_q;
		ex_s1_q <= ext_clk_i;
		ex_s2_q <= ex_s1_q;
		ex_p_q  <= ex_s2_q;
		pn_s1_q <= chan_pin_i;
		pn_s2_q <= pn_s1_q;
		pn_p_q  <= pn_s2_q;
	end

	// read data, prescaler and counter
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_q <= `TCC_ZERO8;
			pre_q   <= 7'h00;
			cnt_q   <= `TCC_ZERO16;
			tick_q  <= 1'b0;
		end else begin
			rdata_q <= read_i ? rd_mux : `TCC_ZERO8;
			if (src_tick && !halt)
				pre_q <= pre_wrap ? 7'h00 : pre_q + 7'h01;
			cnt_q   <= cnt_d;
			tick_q  <= tick;
		end
	end

	// main status/control and overflow flag
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ovf_q     <= 1'b0;
			ovf_arm_q <= 1'b0;
			ovfie_q   <= 1'b0;
			cpwm_q    <= 1'b0;
			clks_q    <= `TCC_CLK_NONE;
			ps_q      <= 3'h0;
		end else begin
			ovf_q     <= ovf_set || (ovf_q && !ovf_clr);
			ovf_arm_q <= !ovf_set && !wr_msc && (ovf_arm_q || (rd_msc && ovf_q));
			if (wr_msc) begin
				ovfie_q <= wdata_i[`TCC_MSC_OVFIE];
				cpwm_q  <= wdata_i[`TCC_MSC_CPWM];
				clks_q  <= wdata_i[`TCC_MSC_CLK_HI:`TCC_MSC_CLK_LO];
				ps_q    <= wdata_i[`TCC_MSC_PS_HI:`TCC_MSC_PS_LO];
			end
		end
	end

	// counter read coherency; frozen by halt except for unlatching writes
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			latched_q  <= 1'b0;
			first_hi_q <= 1'b0;
			hold_q     <= `TCC_ZERO16;
		end else if (wr_msc || wr_cnt) begin
			latched_q  <= 1'b0;
		end else if (!halt && (rd_cnth || rd_cntl)) begin
			if (!latched_q) begin
				latched_q  <= 1'b1;
				first_hi_q <= rd_cnth;
				hold_q     <= cnt_q;
			end else if (rd_cnth != first_hi_q) begin
				latched_q  <= 1'b0;
			end
		end
	end

	// modulo buffer and active value
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mod_q     <= `TCC_ZERO16;
			mod_buf_q <= `TCC_ZERO16;
			mwr_hi_q  <= 1'b0;
			mwr_lo_q  <= 1'b0;
			mod_rdy_q <= 1'b0;
			mod_wrap_q <= 1'b0;
		end else if (halt && (wr_modh || wr_modl)) begin
			if (wr_modh)
				mod_q[15:8] <= wdata_i;
			else
				mod_q[7:0]  <= wdata_i;
		end else begin
			if (wr_modh || wr_modl)
				mod_buf_q <= mod_new;
			if (wr_msc) begin
				mwr_hi_q <= 1'b0;
				mwr_lo_q <= 1'b0;
			end else if (mod_done) begin
				mwr_hi_q <= 1'b0;
				mwr_lo_q <= 1'b0;
			end else begin
				mwr_hi_q <= mwr_hi_q || wr_modh;
				mwr_lo_q <= mwr_lo_q || wr_modl;
			end
			if (mod_done && clks_q == `TCC_CLK_NONE) begin
				mod_q     <= mod_new;
				mod_rdy_q <= 1'b0;
			end else if (mod_done) begin
				mod_rdy_q <= 1'b1;
			end else if (mod_apply) begin
				mod_q     <= mod_buf_q;
				mod_rdy_q <= 1'b0;
			end
			// counter sits on the old top for one tick after the swap
			if (mod_apply && !wr_cnt)
				mod_wrap_q <= 1'b1;
			else if (tick || wr_cnt)
				mod_wrap_q <= 1'b0;
		end
	end

	// channel control, flag and value
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cflag_q <= 1'b0;
			carm_q  <= 1'b0;
			cie_q   <= 1'b0;
			cmsb_q  <= 1'b0;
			cmsa_q  <= 1'b0;
			els_q   <= `TCC_ELS_OFF;
			cval_q  <= `TCC_ZERO16;
		end else begin
			cflag_q <= ch_set || (cflag_q && !ch_clr);
			carm_q  <= !ch_set && !wr_csc && (carm_q || (rd_csc && cflag_q));
			if (wr_csc) begin
				cie_q  <= wdata_i[`TCC_CSC_IE];
				cmsb_q <= wdata_i[`TCC_CSC_MSB];
				cmsa_q <= wdata_i[`TCC_CSC_MSA];
				els_q  <= wdata_i[`TCC_CSC_ELS_HI:`TCC_CSC_ELS_LO];
			end
			if (cap_evt)
				cval_q <= cnt_q;
			else if (wr_cvh && mode != tcc_pkg::TCC_MODE_CAPTURE)
				cval_q[15:8] <= wdata_i;
			else if (wr_cvl && mode != tcc_pkg::TCC_MODE_CAPTURE)
				cval_q[7:0] <= wdata_i;
		end
	end

	// channel pin level driven while the output enable is high
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pin_q <= 1'b0;
		end else if (mode == tcc_pkg::TCC_MODE_COMPARE && match) begin
			case (els_q)
				`TCC_ELS_01: pin_q <= !pin_q;
				`TCC_ELS_10: pin_q <= 1'b0;
				`TCC_ELS_11: pin_q <= 1'b1;
				default:     pin_q <= pin_q;
			endcase
		end else if (mode == tcc_pkg::TCC_MODE_EPWM && els_q != `TCC_ELS_OFF) begin
			if (match && !duty_edge)
				pin_q <= els_q[0];
			else if (tick_q && cnt_q == `TCC_ZERO16)
				pin_q <= cval_q == `TCC_ZERO16 ? els_q[0] : !els_q[0];
		end
	end

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	sequence flag_read_s;
		rd_csc && cflag_q && !ch_set;
	endsequence
	sequence flag_zero_s;
		wr_csc && !wdata_i[`TCC_CSC_FLAG] && !ch_set;
	endsequence

	cnt_clear_a: assert property (wr_cnt |=> cnt_q == `TCC_ZERO16)
		else $error("counter not cleared by counter write");
	halt_freeze_a: assert property (halt && !wr_cnt |=> $stable(cnt_q))
		else $error("counter moved during halt");
	stop_clock_a: assert property (clks_q == `TCC_CLK_NONE && !wr_cnt |=> $stable(cnt_q))
		else $error("counter moved with no clock");
	ovf_wrap_a: assert property (tick && at_top && !mod_pend |=> ovf_q && cnt_q == `TCC_ZERO16)
		else $error("overflow missed at modulo");
	ovf_inhibit_a: assert property (mod_pend && !ovf_q |=> !ovf_q)
		else $error("overflow set during half modulo write");
	cnt_latch_a: assert property (rd_cnth && !latched_q && !halt && !wr_msc
		|=> latched_q && hold_q == $past(cnt_q))
		else $error("counter copy not latched");
	msc_unlatch_a: assert property (wr_msc |=> !latched_q && !mwr_hi_q && !mwr_lo_q)
		else $error("control write left latches set");
	halt_mod_a: assert property (halt && wr_modl |=> mod_q[7:0] == $past(wdata_i))
		else $error("halt modulo write not direct");
	flag_clear_a: assert property (flag_read_s ##1 (!read_i && !ch_set) ##0 flag_zero_s
		|=> !cflag_q)
		else $error("channel flag not cleared");

endmodule

/* File: test/tcc_timer_tb_top.sv */
// self-checking bench for the timer block: register tasks and directed tests
// assumes the register header on the include path and the design compiled first
`timescale 1ns/100ps
`include "tcc_regs.svh"

module tcc_timer_tb_top;
	logic        clk_i = 1'h0;
	logic        reset_i = 1'h1;
	logic        write_i = 1'h0;
	logic        read_i = 1'h0;
	logic        halt = 1'h1;
	logic        cpin = 1'h0;
	logic [2:0]  addr_i = 3'h0;
	logic [7:0]  wdata_i = 8'h00;
	logic [3:0]  dv = 4'h0;
	logic [7:0]  rdata_o, g, lo;
	logic        pin_o, oe_o, oirq, cirq;
	logic [2:0]  p;
	logic [15:0] v, w, x, y;
	int          err_count = 0, checks = 0, ac = 0, base, a1, a2, a4, a5;
	int          te[4] = '{0, 1024, 128, 64};
	logic [7:0]  cs[7] = '{8'h50, 8'h58, 8'h5c, 8'h68, 8'h64, 8'h6c, 8'h54};

	// 40 MHz clock; slow pins divided from it, fixed 1/8 and external 1/16
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) dv <= dv + 4'h1;
	// cycles in which the counter may run, used to predict counter values
	always @(posedge clk_i) if (!halt) ac <= ac + 1;

	tcc_timer u_tcc_timer (.clk_i, .reset_i, .addr_i, .wdata_i, .write_i, .read_i, .rdata_o,
		.debug_halt_i(halt), .fixed_clk_i(dv[2]), .ext_clk_i(dv[3]), .chan_pin_i(cpin),
		.chan_pin_o(pin_o), .chan_pin_oe_o(oe_o), .overflow_irq_o(oirq), .chan_irq_o(cirq));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// register port: strobes last one cycle, read data sampled mid answer cycle
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		write_i <= 1'h1;
		@(posedge clk_i);
		write_i <= 1'h0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		read_i <= 1'h1;
		@(posedge clk_i);
		read_i <= 1'h0;
		@(negedge clk_i);
		d = rdata_o;
	endtask
	task automatic rdc(input logic [2:0] a, input logic [7:0] e);
		rd(a, g);
		chk(g, e);
	endtask
	task automatic rd16(output logic [15:0] r);
		rd(`TCC_OFS_CNT_HI, r[15:8]);
		rd(`TCC_OFS_CNT_LO, r[7:0]);
	endtask
	task automatic hlt(input logic h);
		@(posedge clk_i);
		halt <= h;
	endtask
	// bounded wait for an interrupt level, overflow (0) or channel (1)
	task automatic wirq(input logic ch);
		int c = 0;
		// step off the edge first: a flag cleared at this edge has not settled yet
		@(negedge clk_i);
		while (((ch ? cirq : oirq) !== 1'h1) && (c < 99)) begin
			@(negedge clk_i);
			c++;
		end
		chk(c < 99, 1'h1);
	endtask
	// counter value near what the run-cycle count predicts; latency slack of 3
	task automatic near(input logic [15:0] got, input int a, input logic [15:0] m);
		chk({15'h0, ((got - 16'(a - base) + 16'h3) & m) <= 16'h6}, 16'h1);
	endtask
	// run exactly 1024 unhalted cycles and compare the counter advance
	task automatic meas(input logic [7:0] sc, input logic [15:0] e);
		wr(`TCC_OFS_MSC, sc);
		rd16(v);
		hlt(1'h0);
		repeat (1024) @(posedge clk_i);
		halt <= 1'h1;
		rd16(w);
		chk(w - v, e);
	endtask
	task automatic clr;
		rd(`TCC_OFS_MSC, g);
		wr(`TCC_OFS_MSC, 8'h48);
	endtask
	// overflow period between two fresh flag sets
	task automatic per(input int e);
		int t;
		wirq(1'h0);
		clr();
		wirq(1'h0);
		t = ac;
		clr();
		wirq(1'h0);
		chk(ac - t, e);
	endtask
	task automatic ev(input logic [7:0] c);
		rd(`TCC_OFS_CSC, g);
		wr(`TCC_OFS_CSC, c);
		wirq(1'h1);
		repeat (2) @(negedge clk_i);
	endtask
	task automatic cap(input logic [7:0] c, input logic l, input logic e);
		rd(`TCC_OFS_CSC, g);
		wr(`TCC_OFS_CSC, c);
		@(posedge clk_i);
		cpin <= l;
		repeat (6) @(negedge clk_i);
		chk(cirq, e);
	endtask

	task automatic summarize;
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// the full sequence needs about 14k cycles; give it about 80k
	initial begin
		#2000000;
		err_count++;
		summarize();
	end

	initial begin
		repeat (8) @(posedge clk_i);
		reset_i <= 1'h0;
		chk({oe_o, oirq, cirq}, 3'h0);
		for (int i = 0; i < 6; i++) rdc(3'(i), 8'h00);
		$display("reset values done");
		// sources first at divide-by-1, then prescale codes upwards
		for (int i = 0; i < 11; i++) begin
			p = (i < 4) ? 3'h0 : 3'(i - 3);
			meas({3'h0, (i < 4) ? 2'(i) : 2'h1, p}, (i < 4) ? 16'(te[i]) : 16'h400 >> p);
		end
		$display("clock and prescale done");
		wr(`TCC_OFS_CNT_LO, 8'h5a);
		rd16(v);
		chk(v, 16'h0);
		wr(`TCC_OFS_MSC, 8'h08);
		hlt(1'h0);
		rd(`TCC_OFS_CNT_LO, w[7:0]);
		a1 = ac;
		repeat (600) @(posedge clk_i);
		rd(`TCC_OFS_CNT_HI, w[15:8]);
		rd(`TCC_OFS_CNT_HI, x[15:8]);
		a2 = ac;
		hlt(1'h1);
		rd16(y);
		a5 = ac;
		hlt(1'h0);
		repeat (600) @(posedge clk_i);
		rd(`TCC_OFS_CNT_LO, x[7:0]);
		rd(`TCC_OFS_CNT_HI, g);
		hlt(1'h1);
		wr(`TCC_OFS_MSC, 8'h08);
		hlt(1'h0);
		repeat (600) @(posedge clk_i);
		rd(`TCC_OFS_CNT_LO, lo);
		a4 = ac;
		hlt(1'h1);
		rd16(v);
		base = ac - int'(v);
		near(w, a1, 16'hffff);
		near(y, a5, 16'hffff);
		near(x, a2, 16'hffff);
		near({8'h0, lo}, a4, 16'h00ff);
		$display("counter coherency done");
		hlt(1'h0);
		wr(`TCC_OFS_MSC, 8'h00);
		wr(`TCC_OFS_CNT_HI, 8'h00);
		wr(`TCC_OFS_MOD_HI, 8'h00);
		wr(`TCC_OFS_MOD_LO, 8'h20);
		rdc(`TCC_OFS_MOD_LO, 8'h20);
		wr(`TCC_OFS_MSC, 8'h48);
		per(33);
		wr(`TCC_OFS_MSC, 8'h48);
		rdc(`TCC_OFS_MSC, 8'hc8);
		wr(`TCC_OFS_MSC, 8'hc8);
		rdc(`TCC_OFS_MSC, 8'hc8);
		wr(`TCC_OFS_MSC, 8'h48);
		rdc(`TCC_OFS_MSC, 8'h48);
		wr(`TCC_OFS_MOD_HI, 8'h00);
		repeat (100) @(posedge clk_i);
		chk(oirq, 1'h0);
		wr(`TCC_OFS_MOD_LO, 8'h10);
		per(17);
		wr(`TCC_OFS_MOD_HI, 8'h00);
		wr(`TCC_OFS_MSC, 8'h48);
		per(17);
		hlt(1'h1);
		wr(`TCC_OFS_MOD_LO, 8'h08);
		hlt(1'h0);
		per(9);
		$display("modulo and overflow done");
		hlt(1'h1);
		wr(`TCC_OFS_MOD_LO, 8'h20);
		hlt(1'h0);
		wr(`TCC_OFS_CSC, 8'h50);
		wr(`TCC_OFS_CVAL_HI, 8'h00);
		wr(`TCC_OFS_CVAL_LO, 8'h05);
		// low two bits written as ones must read back as zero
		for (int i = 0; i < 7; i++) begin
			ev(cs[i] | 8'h03);
			chk(oe_o, cs[i][3:2] != 2'h0);
			if (i > 0 && i < 6) chk(pin_o, cs[i][2]);
			rdc(`TCC_OFS_CSC, cs[i] | 8'h80);
		end
		y[0] = pin_o;
		ev(8'h54);
		chk(pin_o, !y[0]);
		wr(`TCC_OFS_CSC, 8'h94);
		@(negedge clk_i);
		chk(cirq, 1'h0);
		rdc(`TCC_OFS_CSC, 8'h94);
		for (int i = 1; i < 4; i++) begin
			cap(8'h40 | 8'(i << 2), 1'h1, i[0]);
			cap(8'h40 | 8'(i << 2), 1'h0, i[1]);
		end
		$display("channel done");
		summarize();
	end
endmodule
